// [logic/plc_ctrl.sv]
// Measurement sequencing, register file and threshold event logic.
`include "plc_defs.svh"

module plc_ctrl
  import plc_pkg::*;
#(
  parameter int unsigned LED_PERIOD_CYCLES =
    `PLC_LED_PERIOD_NS / `PLC_CLK_NS,
  parameter int unsigned TICK_CYCLES =
    `PLC_WAIT_UNIT_MS * `PLC_NS_PER_MS / `PLC_CLK_NS
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic INT_AUTO_CLEAR,
  input wire logic INT_EDGE_MODE,
  input wire logic EVENT_ACK,
  input wire logic LIGHT_HYST_EN,
  input wire logic LIGHT_HYST_UPPER,
  input wire logic [15:0] LIGHT_RESULT_PRIMARY,
  input wire logic LIGHT_VALID,
  input wire logic [15:0] PROX_RESULT,
  output logic LED_DRIVE,
  output logic SENSE_POWER,
  output logic LIGHT_BLANK,
  output logic PROX_DONE,
  output logic PROX_EVENT,
  output logic LIGHT_EVENT,
  output logic IRQ
);

  localparam logic [7:0] PER_LAST = 8'(LED_PERIOD_CYCLES - 1);
  localparam logic [7:0] PER_HALF = 8'(LED_PERIOD_CYCLES / 2);
  localparam logic [20:0] TICK_LAST = 21'(TICK_CYCLES - 1);

  // Pulses per integration period for each code.
  function automatic logic [11:0] pulse_total(input logic [2:0] code);
    logic [11:0] t;
    t = 12'h000;
    case (code)
      3'h0: t = 12'(`PLC_INTEG_US_0 * `PLC_NS_PER_US / `PLC_LED_PERIOD_NS);
      3'h1: t = 12'(`PLC_INTEG_US_1 * `PLC_NS_PER_US / `PLC_LED_PERIOD_NS);
      3'h2: t = 12'(`PLC_INTEG_US_2 * `PLC_NS_PER_US / `PLC_LED_PERIOD_NS);
      3'h3: t = 12'(`PLC_INTEG_US_3 * `PLC_NS_PER_US / `PLC_LED_PERIOD_NS);
      3'h4: t = 12'(`PLC_INTEG_US_4 * `PLC_NS_PER_US / `PLC_LED_PERIOD_NS);
      3'h5: t = 12'(`PLC_INTEG_US_5 * `PLC_NS_PER_US / `PLC_LED_PERIOD_NS);
      3'h6: t = 12'(`PLC_INTEG_US_6 * `PLC_NS_PER_US / `PLC_LED_PERIOD_NS);
      default: t = 12'(`PLC_INTEG_US_7 * `PLC_NS_PER_US /
        `PLC_LED_PERIOD_NS);
    endcase
    return t;
  endfunction

  // Counts exceeding results among the newest n of the history.
  function automatic logic [4:0] count_hits(input logic [14:0] h,
                                            input logic [3:0] n);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 15; i++) begin
      if (i < int'(n) && h[i]) begin
        c = c + 5'h01;
      end
    end
    return c;
  endfunction

  logic [7:0] prox_up_hi, prox_up_lo, prox_lo_hi, prox_lo_lo;
  logic [7:0] light_up_hi, light_up_lo, light_lo_hi, light_lo_lo;
  logic [7:0] prox_event_filter, light_event_filter;
  logic [5:0] prox_measure_config;
  logic [6:0] prox_repeat_interval;
  logic prox_single_run, prox_periodic_run;

  plc_state_t state, next_state;
  logic [7:0] per_cnt, next_per_cnt;
  logic [11:0] pulse_cnt, next_pulse_cnt;
  logic [11:0] run_total, next_run_total;
  logic [20:0] tick_cnt, next_tick_cnt;
  logic [6:0] wait_cnt, next_wait_cnt;
  logic [7:0] rd_mux;
  logic [1:0] ch_evt, next_evt;

  wire wr_prox_up_hi = REG_WR && REG_ADDR == `PLC_OFF_PROX_UP_HI;
  wire wr_prox_up_lo = REG_WR && REG_ADDR == `PLC_OFF_PROX_UP_LO;
  wire wr_prox_lo_hi = REG_WR && REG_ADDR == `PLC_OFF_PROX_LO_HI;
  wire wr_prox_lo_lo = REG_WR && REG_ADDR == `PLC_OFF_PROX_LO_LO;
  wire wr_prox_filt = REG_WR && REG_ADDR == `PLC_OFF_PROX_FILTER;
  wire wr_prox_cfg = REG_WR && REG_ADDR == `PLC_OFF_PROX_CONFIG;
  wire wr_prox_int = REG_WR && REG_ADDR == `PLC_OFF_PROX_INTERVAL;
  wire wr_prox_ctl = REG_WR && REG_ADDR == `PLC_OFF_PROX_CONTROL;
  wire wr_light_up_hi = REG_WR && REG_ADDR == `PLC_OFF_LIGHT_UP_HI;
  wire wr_light_up_lo = REG_WR && REG_ADDR == `PLC_OFF_LIGHT_UP_LO;
  wire wr_light_lo_hi = REG_WR && REG_ADDR == `PLC_OFF_LIGHT_LO_HI;
  wire wr_light_lo_lo = REG_WR && REG_ADDR == `PLC_OFF_LIGHT_LO_LO;
  wire wr_light_filt = REG_WR && REG_ADDR == `PLC_OFF_LIGHT_FILTER;

  wire blank_en = prox_measure_config[`PLC_CFG_BLANK];
  wire per_last = per_cnt == PER_LAST;
  wire pulse_last = pulse_cnt == run_total - 12'h001;
  wire tick_last = tick_cnt == TICK_LAST;
  wire wait_last = wait_cnt == prox_repeat_interval;
  wire led_on = state == PLC_PULSE && per_cnt < PER_HALF;
  wire start_req = prox_single_run || prox_periodic_run;

  // Register file; the measurement end clears the single-run bit.
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prox_up_hi <= `PLC_RST_UP_BYTE;
      prox_up_lo <= `PLC_RST_UP_BYTE;
      prox_lo_hi <= `PLC_RST_LO_BYTE;
      prox_lo_lo <= `PLC_RST_LO_BYTE;
      light_up_hi <= `PLC_RST_UP_BYTE;
      light_up_lo <= `PLC_RST_UP_BYTE;
      light_lo_hi <= `PLC_RST_LO_BYTE;
      light_lo_lo <= `PLC_RST_LO_BYTE;
      prox_event_filter <= `PLC_RST_FILTER;
      light_event_filter <= `PLC_RST_FILTER;
      prox_measure_config <= `PLC_RST_CONFIG;
      prox_repeat_interval <= `PLC_RST_INTERVAL;
      prox_single_run <= 1'b0;
      prox_periodic_run <= 1'b0;
    end else begin
      if (wr_prox_up_hi) prox_up_hi <= REG_WDATA;
      if (wr_prox_up_lo) prox_up_lo <= REG_WDATA;
      if (wr_prox_lo_hi) prox_lo_hi <= REG_WDATA;
      if (wr_prox_lo_lo) prox_lo_lo <= REG_WDATA;
      if (wr_light_up_hi) light_up_hi <= REG_WDATA;
      if (wr_light_up_lo) light_up_lo <= REG_WDATA;
      if (wr_light_lo_hi) light_lo_hi <= REG_WDATA;
      if (wr_light_lo_lo) light_lo_lo <= REG_WDATA;
      if (wr_prox_filt) prox_event_filter <= REG_WDATA;
      if (wr_light_filt) light_event_filter <= REG_WDATA;
      if (wr_prox_cfg) prox_measure_config <= REG_WDATA[5:0];
      if (wr_prox_int) prox_repeat_interval <= REG_WDATA[6:0];
      if (wr_prox_ctl) begin
        prox_single_run <= REG_WDATA[`PLC_CTL_SINGLE];
        prox_periodic_run <= REG_WDATA[`PLC_CTL_PERIODIC];
      end else if (state == PLC_DONE) begin
        prox_single_run <= 1'b0;
      end
    end
  end

  // Read data selection; unmapped and reserved bits read zero.
  always_comb begin
    if (REG_ADDR == `PLC_OFF_PROX_UP_HI) begin
      rd_mux = prox_up_hi;
    end else if (REG_ADDR == `PLC_OFF_PROX_UP_LO) begin
      rd_mux = prox_up_lo;
    end else if (REG_ADDR == `PLC_OFF_PROX_LO_HI) begin
      rd_mux = prox_lo_hi;
    end else if (REG_ADDR == `PLC_OFF_PROX_LO_LO) begin
      rd_mux = prox_lo_lo;
    end else if (REG_ADDR == `PLC_OFF_PROX_FILTER) begin
      rd_mux = prox_event_filter;
    end else if (REG_ADDR == `PLC_OFF_PROX_CONFIG) begin
      rd_mux = {2'b00, prox_measure_config};
    end else if (REG_ADDR == `PLC_OFF_PROX_INTERVAL) begin
      rd_mux = {1'b0, prox_repeat_interval};
    end else if (REG_ADDR == `PLC_OFF_PROX_CONTROL) begin
      rd_mux = {6'h00, prox_periodic_run, prox_single_run};
    end else if (REG_ADDR == `PLC_OFF_LIGHT_UP_HI) begin
      rd_mux = light_up_hi;
    end else if (REG_ADDR == `PLC_OFF_LIGHT_UP_LO) begin
      rd_mux = light_up_lo;
    end else if (REG_ADDR == `PLC_OFF_LIGHT_LO_HI) begin
      rd_mux = light_lo_hi;
    end else if (REG_ADDR == `PLC_OFF_LIGHT_LO_LO) begin
      rd_mux = light_lo_lo;
    end else if (REG_ADDR == `PLC_OFF_LIGHT_FILTER) begin
      rd_mux = light_event_filter;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Measurement sequencer.
  always_comb begin
    next_state = state;
    next_per_cnt = per_cnt;
    next_pulse_cnt = pulse_cnt;
    next_run_total = run_total;
    next_tick_cnt = tick_cnt;
    next_wait_cnt = wait_cnt;
    case (state)
      PLC_IDLE: begin
        if (start_req) begin
          next_state = PLC_PULSE;
          next_per_cnt = 8'h00;
          next_pulse_cnt = 12'h000;
          next_run_total = pulse_total(prox_measure_config[2:0]);
        end
      end
      PLC_PULSE: begin
        next_per_cnt = per_last ? 8'h00 : per_cnt + 8'h01;
        if (per_last) begin
          next_pulse_cnt = pulse_cnt + 12'h001;
          if (pulse_last) begin
            next_state = PLC_DONE;
          end
        end
      end
      PLC_DONE: begin
        next_tick_cnt = 21'h000000;
        next_wait_cnt = 7'h00;
        next_state = prox_periodic_run ? PLC_WAIT : PLC_IDLE;
      end
      default: begin
        next_tick_cnt = tick_last ? 21'h000000 : tick_cnt + 21'h000001;
        if (tick_last) begin
          next_wait_cnt = wait_cnt + 7'h01;
        end
        if (!prox_periodic_run) begin
          next_state = PLC_IDLE;
        end else if (tick_last && wait_last) begin
          next_state = PLC_PULSE;
          next_per_cnt = 8'h00;
          next_pulse_cnt = 12'h000;
          next_run_total = pulse_total(prox_measure_config[2:0]);
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= PLC_IDLE;
      per_cnt <= 8'h00;
      pulse_cnt <= 12'h000;
      run_total <= 12'h000;
      tick_cnt <= 21'h000000;
      wait_cnt <= 7'h00;
    end else begin
      state <= next_state;
      per_cnt <= next_per_cnt;
      pulse_cnt <= next_pulse_cnt;
      run_total <= next_run_total;
      tick_cnt <= next_tick_cnt;
      wait_cnt <= next_wait_cnt;
    end
  end

  // Per-channel event logic: index 0 proximity, index 1 light.
  logic [15:0] ch_res [2];
  logic [15:0] ch_up [2];
  logic [15:0] ch_lo [2];
  logic [7:0] ch_filt [2];
  logic [1:0] ch_hyst_en, ch_hyst_up, ch_valid;

  assign ch_res[0] = PROX_RESULT;
  assign ch_res[1] = LIGHT_RESULT_PRIMARY;
  assign ch_up[0] = {prox_up_hi, prox_up_lo};
  assign ch_up[1] = {light_up_hi, light_up_lo};
  assign ch_lo[0] = {prox_lo_hi, prox_lo_lo};
  assign ch_lo[1] = {light_lo_hi, light_lo_lo};
  assign ch_filt[0] = prox_event_filter;
  assign ch_filt[1] = light_event_filter;
  assign ch_hyst_en = {LIGHT_HYST_EN,
                       prox_measure_config[`PLC_CFG_HYST_EN]};
  assign ch_hyst_up = {LIGHT_HYST_UPPER,
                       prox_measure_config[`PLC_CFG_HYST_UP]};
  assign ch_valid = {LIGHT_VALID, state == PLC_DONE};

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [14:0] hist;
    wire [3:0] n_cnt = ch_filt[ch][7:4];
    wire [3:0] m_cnt = ch_filt[ch][3:0];
    wire hyst = ch_hyst_en[ch] && INT_AUTO_CLEAR;
    wire above = ch_res[ch] > ch_up[ch];
    wire below = ch_res[ch] < ch_lo[ch];
    wire beyond = hyst ? (ch_hyst_up[ch] ? above : below)
                       : (above || below);
    wire clear_hit = hyst && (ch_hyst_up[ch] ? below : above);
    wire [14:0] next_hist = {hist[13:0], beyond};
    wire [4:0] hits = count_hits(next_hist, n_cnt);
    wire pass = n_cnt != 4'h0 && m_cnt != 4'h0 &&
                hits >= {1'b0, m_cnt};
    wire [1:0] hold_set = {pass, clear_hit};

    always_comb begin
      if (!INT_AUTO_CLEAR) begin
        next_evt[ch] = (ch_valid[ch] && pass) ||
                       (ch_evt[ch] && !EVENT_ACK);
      end else if (!ch_valid[ch]) begin
        next_evt[ch] = ch_evt[ch];
      end else if (!hyst || n_cnt == 4'h0 || m_cnt == 4'h0) begin
        next_evt[ch] = pass;
      end else begin
        case (hold_set)
          2'b10, 2'b11: next_evt[ch] = 1'b1;
          2'b01: next_evt[ch] = 1'b0;
          default: next_evt[ch] = ch_evt[ch];
        endcase
      end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        hist <= 15'h0000;
        ch_evt[ch] <= 1'b0;
      end else begin
        if (ch_valid[ch]) hist <= next_hist;
        ch_evt[ch] <= next_evt[ch];
      end
    end

    property p_zero_filter;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      ch_valid[ch] && INT_AUTO_CLEAR && (n_cnt == 4'h0 || m_cnt == 4'h0)
      |=> !ch_evt[ch];
    endproperty
    a_zero_filter: assert property (p_zero_filter)
      else $error("Event set with a zero filter count.");

    property p_window;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      ch_valid[ch] && INT_AUTO_CLEAR && !ch_hyst_en[ch] &&
      ch_filt[ch] == 8'h11 && (above || below) |=> ch_evt[ch];
    endproperty
    a_window: assert property (p_window)
      else $error("Result outside window did not raise the event.");
  end

  wire meas_end = |ch_valid;

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
      LED_DRIVE <= 1'b0;
      SENSE_POWER <= 1'b0;
      LIGHT_BLANK <= 1'b0;
      PROX_DONE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      if (REG_RD) REG_RDATA <= rd_mux;
      LED_DRIVE <= led_on;
      SENSE_POWER <= state == PLC_PULSE;
      LIGHT_BLANK <= led_on && blank_en;
      PROX_DONE <= state == PLC_DONE;
      IRQ <= INT_EDGE_MODE ? meas_end && |next_evt : |next_evt;
    end
  end

  assign PROX_EVENT = ch_evt[0];
  assign LIGHT_EVENT = ch_evt[1];

  sequence s_wait_over;
    state == PLC_WAIT && tick_last && wait_last && prox_periodic_run;
  endsequence

  sequence s_meas_end;
    state == PLC_DONE;
  endsequence

  property p_pulse_bound;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    state == PLC_PULSE |-> pulse_cnt < run_total;
  endproperty
  a_pulse_bound: assert property (p_pulse_bound)
    else $error("Pulse count ran past the integration total.");

  property p_single_clear;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    s_meas_end ##0 !wr_prox_ctl |=> !prox_single_run;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("Single-run bit not cleared at measurement end.");

  property p_power_down;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    s_meas_end |=> !SENSE_POWER && !LED_DRIVE;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("LED or sensing left powered after measurement.");

  property p_blank;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    LIGHT_BLANK == (LED_DRIVE && $past(blank_en));
  endproperty
  a_blank: assert property (p_blank)
    else $error("Blanking does not follow the LED drive.");

  property p_wait_bound;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    state == PLC_WAIT |-> wait_cnt <= prox_repeat_interval;
  endproperty
  a_wait_bound: assert property (p_wait_bound)
    else $error("Repeat wait ran past the programmed interval.");

  property p_periodic_restart;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    s_wait_over |=> state == PLC_PULSE ##1 SENSE_POWER;
  endproperty
  a_periodic_restart: assert property (p_periodic_restart)
    else $error("Repeat mode did not restart after the interval.");

  property p_no_restart;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    state == PLC_PULSE && !(per_last && pulse_last) |=>
      state == PLC_PULSE && $stable(run_total);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("Running measurement was disturbed.");

  property p_edge_irq;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    INT_EDGE_MODE && !meas_end |=> !IRQ;
  endproperty
  a_edge_irq: assert property (p_edge_irq)
    else $error("Edge interrupt outside a measurement end.");

endmodule

// [logic/plc_defs.svh]
// Register map, field positions, reset values and timing constants.
// Function
// - LED pulse count in a measurement follows integration time at 1.5 us period.
// - Integration code 000..111 selects 150..4800 us; resets to 011.
// - Proximity config bit 5 enables hysteresis, bit 4 picks direction; reset zero.
// - Blanking bit 3, reset one, suspends light sensing while LED fires.
// - Repeat wait is seven-bit field times 10 ms plus 10 ms; reset 0x04.
// - While repeat bit 1 is set, start measurements at every interval.
// - Writing one to bit 0 starts one measurement; bit self-clears at end.
// - LED driver and sensing power drop as soon as a measurement ends.
// - Without hysteresis, a light result outside the window raises the event.
// - Hysteresis upper trigger: set above upper limit, clear below lower.
// - Hysteresis lower trigger: set below lower limit, clear above upper.
// - Hysteresis acts only in automatic-clear mode.
// - Light limits: upper 0x20/0x21 reset 0xFF, lower 0x22/0x23 reset 0x00.
// - Filter byte holds N in 7:4, M in 3:0; M of last N must exceed.
// - Reset filter of one out of one passes any single exceeding result.
// - Host keeps N not below M; a zero count suppresses light events.
// - Proximity results use the same window and hysteresis rules.
// - Proximity filter uses the same M of N rule; zero suppresses.
// - Automatic-clear mode re-evaluates the event after every measurement.
// - Edge mode pulses the interrupt at each measurement end while set.
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

`define PLC_CLK_NS 8
`define PLC_LED_PERIOD_NS 1500
`define PLC_WAIT_UNIT_MS 10
`define PLC_NS_PER_MS 1000000
`define PLC_NS_PER_US 1000

`define PLC_INTEG_US_0 150
`define PLC_INTEG_US_1 300
`define PLC_INTEG_US_2 600
`define PLC_INTEG_US_3 1200
`define PLC_INTEG_US_4 1800
`define PLC_INTEG_US_5 2400
`define PLC_INTEG_US_6 3600
`define PLC_INTEG_US_7 4800

`define PLC_OFF_PROX_UP_HI 8'h10
`define PLC_OFF_PROX_UP_LO 8'h11
`define PLC_OFF_PROX_LO_HI 8'h12
`define PLC_OFF_PROX_LO_LO 8'h13
`define PLC_OFF_PROX_FILTER 8'h14
`define PLC_OFF_PROX_CONFIG 8'h15
`define PLC_OFF_PROX_INTERVAL 8'h16
`define PLC_OFF_PROX_CONTROL 8'h17
`define PLC_OFF_LIGHT_UP_HI 8'h20
`define PLC_OFF_LIGHT_UP_LO 8'h21
`define PLC_OFF_LIGHT_LO_HI 8'h22
`define PLC_OFF_LIGHT_LO_LO 8'h23
`define PLC_OFF_LIGHT_FILTER 8'h24

`define PLC_RST_FILTER 8'h11
`define PLC_RST_CONFIG 6'h0B
`define PLC_RST_INTERVAL 7'h04
`define PLC_RST_UP_BYTE 8'hFF
`define PLC_RST_LO_BYTE 8'h00

`define PLC_CFG_HYST_EN 5
`define PLC_CFG_HYST_UP 4
`define PLC_CFG_BLANK 3
`define PLC_CTL_PERIODIC 1
`define PLC_CTL_SINGLE 0

`endif

// [logic/plc_pkg.sv]
// Types shared by the proximity and light measurement control.
package plc_pkg;
  typedef enum logic [1:0] {
    PLC_IDLE = 2'b00,
    PLC_PULSE = 2'b01,
    PLC_DONE = 2'b11,
    PLC_WAIT = 2'b10
  } plc_state_t;
endpackage

// [test/plc_host_model.sv]
// Host model that reaches the registers through the register port.
module plc_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Address and data are inverted once released so stale values never match.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    #1;
    d = rdata;
  endtask
endmodule

// [test/prox_light_measure_threshold_ctrl_tb_top.sv]
// Self-checking bench for the measurement and threshold control.
module prox_light_measure_threshold_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, auto_clr, edge_md, ack, hen, hup, lval;
  logic led, sense, blank, pdone, pev, lev, irq, ev;
  logic [7:0] rdata, addr, wdata, d;
  logic [15:0] lres, pres, up, lo, r;
  logic [31:0] seed, a;
  int miscompares, tests_run, cyc, on, g, led_n;
  logic [7:0] offs [14] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
    8'h17, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30};
  logic [7:0] rstv [14] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h11, 8'h0B, 8'h04,
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h11, 8'h00};
  plc_host_model host (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));
  plc_ctrl #(.LED_PERIOD_CYCLES(8), .TICK_CYCLES(20)) dut (
    .SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .INT_AUTO_CLEAR(auto_clr),
    .INT_EDGE_MODE(edge_md), .EVENT_ACK(ack), .LIGHT_HYST_EN(hen),
    .LIGHT_HYST_UPPER(hup), .LIGHT_RESULT_PRIMARY(lres),
    .LIGHT_VALID(lval), .PROX_RESULT(pres), .LED_DRIVE(led),
    .SENSE_POWER(sense), .LIGHT_BLANK(blank), .PROX_DONE(pdone),
    .PROX_EVENT(pev), .LIGHT_EVENT(lev), .IRQ(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected light event from the window or hysteresis settings.
  function automatic logic exp_light(input logic [15:0] v,
    input logic h, input logic u, input logic prev);
    logic hi;
    logic lw;
    hi = v > up;
    lw = v < lo;
    if (!h) return hi | lw;
    if (u) return hi ? 1'b1 : (lw ? 1'b0 : prev);
    return lw ? 1'b1 : (hi ? 1'b0 : prev);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic set_lim(input logic [15:0] u, input logic [15:0] l);
    up = u;
    lo = l;
    host.wr_reg(8'h20, u[15:8]);
    host.wr_reg(8'h21, u[7:0]);
    host.wr_reg(8'h22, l[15:8]);
    host.wr_reg(8'h23, l[7:0]);
  endtask
  task automatic light(input logic [15:0] v, input logic h, input logic u);
    @(posedge clk);
    lres <= v;
    hen <= h;
    hup <= u;
    lval <= 1'b1;
    @(posedge clk);
    lval <= 1'b0;
    lres <= ~v;
    #1;
  endtask
  task automatic run_meas(input logic bl, output int n);
    n = 0;
    led_n = 0;
    for (int k = 0; k < 20000; k++) begin
      @(posedge clk);
      #1;
      if (sense === 1'b1) n++;
      if (led === 1'b1) led_n++;
      if (blank !== (led & bl)) chk(16'(blank), 16'(led & bl));
      if (pdone === 1'b1) break;
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    seed = 32'd15739;
    rst = 1'b1;
    {auto_clr, edge_md, ack, hen, hup, lval, ev} = 7'b1000000;
    lres = 16'h0000;
    pres = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      host.rd_reg(offs[i], d);
      chk(16'(d), 16'(rstv[i]));
    end
    host.wr_reg(8'h16, 8'hFF);
    host.rd_reg(8'h16, d);
    chk(16'(d), 16'h007F);
    for (int i = 0; i < 24; i++) begin
      if (i % 8 == 0) begin
        a = rnd();
        set_lim(a[15:0] > a[31:16] ? a[15:0] : a[31:16],
          a[15:0] > a[31:16] ? a[31:16] : a[15:0]);
      end
      a = rnd();
      case (a[2:0])
        3'h0: r = up;
        3'h1: r = up + 16'h0001;
        3'h2: r = lo - 16'h0001;
        3'h3: r = lo;
        default: r = a[31:16];
      endcase
      ev = exp_light(r, a[3], a[4], ev);
      light(r, a[3], a[4]);
      chk(16'(lev), 16'(ev));
      chk(16'(irq), 16'(ev));
    end
    set_lim(16'h1000, 16'h0100);
    light(16'h0800, 1'b0, 1'b0);
    @(posedge clk);
    auto_clr <= 1'b0;
    light(16'h2000, 1'b1, 1'b0);
    chk(16'(lev), 16'h0001);
    light(16'h0800, 1'b1, 1'b0);
    chk(16'(lev), 16'h0001);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(lev), 16'h0000);
    @(posedge clk);
    auto_clr <= 1'b1;
    edge_md <= 1'b1;
    repeat (2) begin
      light(16'h2000, 1'b0, 1'b0);
      chk(16'(irq), 16'h0001);
      @(posedge clk);
      #1;
      chk(16'(irq), 16'h0000);
    end
    @(posedge clk);
    edge_md <= 1'b0;
    repeat (2) light(16'h0800, 1'b0, 1'b0);
    // Host keeps N not below M except where a zero count is probed.
    host.wr_reg(8'h24, 8'h32);
    for (int i = 0; i < 8; i++) begin
      if (i == 6) host.wr_reg(8'h24, 8'h10);
      if (i == 7) host.wr_reg(8'h24, 8'h01);
      r = (i == 3 || i > 4) ? 16'h2000 : 16'h0800;
      light(r, 1'b0, 1'b0);
      chk(16'(lev), 16'(i == 5));
    end
    host.wr_reg(8'h10, 8'h01);
    host.wr_reg(8'h11, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pres <= (i == 0 || i == 3) ? 16'h0300 :
        (i == 1 ? 16'h0400 : 16'h0050);
      host.wr_reg(8'h14, (i == 1) ? 8'h10 : 8'h11);
      host.wr_reg(8'h15, (i == 1) ? 8'h01 :
        (i == 3 ? 8'h2B : (8'h08 | 8'(i))));
      host.wr_reg(8'h17, 8'h01);
      fork
        host.wr_reg(8'h17, 8'h01);
      join_none
      run_meas(i != 1, on);
      chk(16'(on), 16'(100 * (1 << i) * 8));
      chk(16'(led_n), 16'(100 * (1 << i) * 4));
      chk(16'(pev), 16'(i == 0));
      chk(16'({led, sense}), 16'h0000);
      host.rd_reg(8'h17, d);
      chk(16'(d), 16'h0000);
      chk(16'(sense), 16'h0000);
    end
    host.wr_reg(8'h16, 8'h02);
    host.wr_reg(8'h15, 8'h08);
    host.wr_reg(8'h17, 8'h02);
    run_meas(1'b1, on);
    g = 0;
    while (sense !== 1'b1 && g < 200) begin
      @(posedge clk);
      #1;
      g++;
    end
    chk(16'(g >= 60 && g <= 62), 16'h0001);
    host.wr_reg(8'h17, 8'h00);
    run_meas(1'b1, on);
    g = 0;
    repeat (80) begin
      @(posedge clk);
      #1;
      if (sense === 1'b1) g++;
    end
    chk(16'(g), 16'h0000);
    conclude();
  end
endmodule
